// ---- rtl/esf_pkg.sv ----
package esf_pkg;
   // ----------------------------------------
   // Frame geometry
   // ----------------------------------------
   localparam logic [3:0] WORDS_FOUR = 4'h4;
   localparam logic [3:0] WORDS_SIX  = 4'h6;
   localparam logic [3:0] WORDS_BUS_ERROR_INPUT = 4'hC;
   localparam logic [3:0] FMT_FOUR   = 4'h0;
   localparam logic [3:0] FMT_SIX    = 4'h2;
   localparam logic [3:0] FMT_BUS_ERROR_INPUT   = 4'hC;
   localparam logic [31:0] WORD_BYTES    = 32'h2;
   localparam logic [31:0] EXC_SP_ADJUST = 32'h6;
   // ----------------------------------------
   // Word index inside a frame, lowest address first
   // ----------------------------------------
   localparam int W_SR  = 0;
   localparam int W_PCH = 1;
   localparam int W_PCL = 2;
   localparam int W_FMT = 3;
   localparam int W_FAH = 4;
   localparam int W_FAL = 5;
   localparam int W_DBH = 6;
   localparam int W_DBL = 7;
   localparam int W_IPH = 8;
   localparam int W_IPL = 9;
   localparam int W_CNT = 10;
   localparam int W_SSW = 11;
   // ----------------------------------------
   // Special status word fields
   // ----------------------------------------
   localparam int SSW_TP = 15;
   localparam int SSW_MV = 14;
   localparam int SSW_ZERO = 13;
   localparam int SSW_TR = 12;
   localparam int SSW_B1 = 11;
   localparam int SSW_B0 = 10;
   localparam int SSW_RR = 9;
   localparam int SSW_RM = 8;
   localparam int SSW_IN = 7;
   localparam int SSW_RW = 6;
   localparam int SSW_LG = 5;
   localparam int SSW_SIZ = 3;
   localparam int SSW_FC = 0;
   localparam logic [1:0] TYPE_NORMAL = 2'b00;
   localparam logic [1:0] TYPE_MOVE   = 2'b01;
   localparam logic [1:0] TYPE_EXC    = 2'b10;
   // ----------------------------------------
   // Exception kinds and bus fault causes
   // ----------------------------------------
   typedef enum logic [3:0] {
      K_INTERRUPT, K_FORMAT, K_TRAPN, K_ILLEGAL, K_LINEA, K_LINEF,
      K_PRIV, K_BOUNDS, K_BOUNDS2, K_CONDTRAP, K_OVFTRAP, K_DIVZERO,
      K_TRACE, K_HWBKPT, K_BUSERR
   } esf_kind_type;
   typedef enum logic [1:0] {
      C_NORMAL, C_MOVE, C_EXC
   } esf_cause_type;
endpackage

// ---- rtl/esf_frame_builder.sv ----
// Functional notes
// - Interrupts, format error, traps, illegal, A/F-line, privilege use four words.
// - Four-word PC is next or faulting address, chosen by kind.
// - Bounds, two-bound, conditional, overflow traps, divide-zero, trace use six words.
// - Six-word frame holds faulting address and next-instruction return PC.
// - Hardware breakpoints use six words; faulted PC is instruction executing then.
// - Any bus fault stacks a twelve-word frame with status word.
// - Status word bit layout 15 down to 0 as packaged.
// - Normal execution faults write type pair 00.
// - Faults during exception processing write 10, stacking from old SP minus six.
// - Multi-register move operand faults write type pair 01.
// - Word at offset 0x14 holds revision and move transfer count.
// - Return checks stacked revision matches this core.
// - Return reloads low count byte only when move bit is set.
// - Dynamically sized cycle records upper byte address, no byte indication.
// - Bus-error frames carry format code C.
// - Return examines rerun bit, never the read/write bit.
// - Continued move refetches, keeps address, rescans mask same count.
`timescale 1ns/1ps
`default_nettype none
module esf_frame_builder
   import esf_pkg::*;
#(
   parameter logic [7:0] MICROCODE_REV = 8'h01  // Value is arbitrary
)(
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic         excStart,
   input  wire esf_kind_type excKind,
   input  wire esf_cause_type berrCause,
   input  wire logic [7:0]   excVector,
   input  wire logic [15:0]  statusWord,
   input  wire logic [31:0]  nextPc,
   input  wire logic [31:0]  faultPc,
   input  wire logic [31:0]  stackPtr,
   input  wire logic [31:0]  spBeforeFault,
   input  wire logic [31:0]  faultAddr,
   input  wire logic         dynSized,
   input  wire logic [31:0]  dataBuf,
   input  wire logic         tracePending,
   input  wire logic         bkptHigh,
   input  wire logic         bkptLow,
   input  wire logic         rerunIn,
   input  wire logic         rmwIn,
   input  wire logic         instrData,
   input  wire logic         readWrite,
   input  wire logic         longOp,
   input  wire logic [1:0]   remainingSize,
   input  wire logic [2:0]   functionCode,
   input  wire logic [7:0]   moveCountIn,
   input  wire logic         rteStart,
   output logic              memReq,
   output logic              memWrite,
   output logic [31:0]       memAddr,
   output logic [15:0]       memWdata,
   input  wire logic         memAck,
   input  wire logic [15:0]  memRdata,
   output logic              busy,
   output logic              excDone,
   output logic              rteDone,
   output logic              rteError,
   output logic [31:0]       stackPtrOut,
   output logic [15:0]       restoredStatus,
   output logic [31:0]       resumePc,
   output logic              moveCountLoad,
   output logic [7:0]        moveCountOut,
   output logic              rerunCycle,
   output logic              moveContinue
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [2:0] {S_IDLE, S_PUSH, S_POP, S_CHECK} esf_state_type;
   esf_state_type state, next_state;
   logic [3:0]  idx, next_idx;
   logic [3:0]  last, next_last;
   logic [31:0] base, next_base;
   logic [15:0] frame [WORDS_BUS_ERROR_INPUT];
   logic [15:0] next_frame [WORDS_BUS_ERROR_INPUT];
   logic        next_memReq, next_memWrite, next_busy;
   logic [31:0] next_memAddr, next_stackPtrOut, next_resumePc;
   logic [15:0] next_memWdata, next_restoredStatus;
   logic        next_excDone, next_rteDone, next_rteError;
   logic        next_moveCountLoad, next_rerunCycle, next_moveContinue;
   logic [7:0]  next_moveCountOut;
   // Combinational helpers
   logic [3:0]  words;
   logic [3:0]  fmt;
   logic [31:0] top, pc4, fa;
   logic [1:0]  tpmv;
   logic [15:0] special_status_word;

   // ----------------------------------------
   // Frame selection and word assembly
   // ----------------------------------------
   always_comb
   begin
      unique case (excKind)
         K_INTERRUPT, K_FORMAT, K_TRAPN, K_ILLEGAL, K_LINEA, K_LINEF, K_PRIV:
         begin
            words = WORDS_FOUR;
            fmt = FMT_FOUR;
         end
         K_BOUNDS, K_BOUNDS2, K_CONDTRAP, K_OVFTRAP, K_DIVZERO, K_TRACE, K_HWBKPT:
         begin
            words = WORDS_SIX;
            fmt = FMT_SIX;
         end
         default:
         begin
            words = WORDS_BUS_ERROR_INPUT;
            fmt = FMT_BUS_ERROR_INPUT;
         end
      endcase
      // Traps return past themselves, faults restart the culprit
      unique case (excKind)
         K_FORMAT, K_ILLEGAL, K_LINEA, K_LINEF, K_PRIV: pc4 = faultPc;
         default: pc4 = nextPc;
      endcase
      unique case (berrCause)
         C_MOVE: tpmv = TYPE_MOVE;
         C_EXC: tpmv = TYPE_EXC;
         default: tpmv = TYPE_NORMAL;
      endcase
      // Exception-time faults stack below the frame that was in progress
      if (excKind == K_BUSERR && berrCause == C_EXC)
         top = spBeforeFault - EXC_SP_ADJUST;
      else
         top = stackPtr;
      // Even address names the upper byte of a split cycle
      fa = faultAddr;
      if (dynSized)
         fa[0] = 1'b0;
      special_status_word = '0;
      special_status_word[SSW_TP:SSW_MV] = tpmv;
      special_status_word[SSW_ZERO] = 1'b0;
      special_status_word[SSW_TR] = tracePending;
      special_status_word[SSW_B1] = bkptHigh;
      special_status_word[SSW_B0] = bkptLow;
      special_status_word[SSW_RR] = rerunIn;
      special_status_word[SSW_RM] = rmwIn;
      special_status_word[SSW_IN] = instrData;
      special_status_word[SSW_RW] = readWrite;
      special_status_word[SSW_LG] = longOp;
      special_status_word[SSW_SIZ +: 2] = remainingSize;
      special_status_word[SSW_FC +: 3] = functionCode;
   end

   // ----------------------------------------
   // Sequencer next values
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      next_idx = idx;
      next_last = last;
      next_base = base;
      for (int i = 0; i < WORDS_BUS_ERROR_INPUT; i++)
         next_frame[i] = frame[i];
      next_memReq = memReq;
      next_memWrite = memWrite;
      next_memAddr = memAddr;
      next_memWdata = memWdata;
      next_busy = busy;
      next_stackPtrOut = stackPtrOut;
      next_restoredStatus = restoredStatus;
      next_resumePc = resumePc;
      next_moveCountOut = moveCountOut;
      next_excDone = 1'b0;
      next_rteDone = 1'b0;
      next_rteError = 1'b0;
      next_moveCountLoad = 1'b0;
      next_rerunCycle = 1'b0;
      next_moveContinue = 1'b0;
      unique case (state)
         S_IDLE:
         begin
            if (excStart)
            begin
               // Capture the whole frame image
               next_frame[W_SR] = statusWord;
               next_frame[W_PCH] = (words == WORDS_FOUR) ? pc4[31:16] : nextPc[31:16];
               next_frame[W_PCL] = (words == WORDS_FOUR) ? pc4[15:0] : nextPc[15:0];
               next_frame[W_FMT] = {fmt, 2'b00, excVector, 2'b00};
               if (words == WORDS_SIX)
               begin
                  next_frame[W_FAH] = faultPc[31:16];
                  next_frame[W_FAL] = faultPc[15:0];
               end
               else
               begin
                  next_frame[W_FAH] = fa[31:16];
                  next_frame[W_FAL] = fa[15:0];
               end
               next_frame[W_DBH] = dataBuf[31:16];
               next_frame[W_DBL] = dataBuf[15:0];
               next_frame[W_IPH] = faultPc[31:16];
               next_frame[W_IPL] = faultPc[15:0];
               next_frame[W_CNT] = {MICROCODE_REV,
                                    (berrCause == C_MOVE) ? moveCountIn : 8'h00};
               next_frame[W_SSW] = special_status_word;
               next_last = words - 4'h1;
               next_idx = words - 4'h1;
               next_base = top - WORD_BYTES * {28'h0, words};
               // Highest word goes out first
               next_memReq = 1'b1;
               next_memWrite = 1'b1;
               next_memAddr = top - WORD_BYTES;
               // First word stands on the data lines together with the request
               next_memWdata = next_frame[words - 4'h1];
               next_busy = 1'b1;
               next_state = S_PUSH;
            end
            else if (rteStart)
            begin
               next_base = stackPtr;
               next_idx = 4'h0;
               next_last = WORDS_FOUR - 4'h1;
               next_memReq = 1'b1;
               next_memWrite = 1'b0;
               next_memAddr = stackPtr;
               next_busy = 1'b1;
               next_state = S_POP;
            end
         end
         S_PUSH:
         begin
            next_memWdata = frame[idx];
            if (memAck && memReq)
            begin
               if (idx == 4'h0)
               begin
                  next_memReq = 1'b0;
                  next_memWrite = 1'b0;
                  next_stackPtrOut = base;
                  next_excDone = 1'b1;
                  next_busy = 1'b0;
                  next_state = S_IDLE;
               end
               else
               begin
                  next_idx = idx - 4'h1;
                  next_memAddr = memAddr - WORD_BYTES;
                  next_memWdata = frame[idx - 4'h1];
               end
            end
         end
         S_POP:
         begin
            if (memAck)
            begin
               next_frame[idx] = memRdata;
               if (idx == 4'(W_FMT))
               begin
                  // Frame length follows from the format code
                  unique case (memRdata[15:12])
                     FMT_FOUR: next_last = WORDS_FOUR - 4'h1;
                     FMT_SIX: next_last = WORDS_SIX - 4'h1;
                     FMT_BUS_ERROR_INPUT: next_last = WORDS_BUS_ERROR_INPUT - 4'h1;
                     default: next_last = 4'hF;
                  endcase
               end
               if (idx == next_last || next_last == 4'hF)
               begin
                  next_memReq = 1'b0;
                  next_state = S_CHECK;
               end
               else
               begin
                  next_idx = idx + 4'h1;
                  next_memAddr = memAddr + WORD_BYTES;
               end
            end
         end
         S_CHECK:
         begin
            next_busy = 1'b0;
            next_rteDone = 1'b1;
            next_state = S_IDLE;
            next_restoredStatus = frame[W_SR];
            next_resumePc = {frame[W_PCH], frame[W_PCL]};
            next_stackPtrOut = base + WORD_BYTES * {28'h0, last + 4'h1};
            if (last == 4'hF)
               next_rteError = 1'b1;
            else if (last == WORDS_BUS_ERROR_INPUT - 4'h1)
            begin
               if (frame[W_CNT][15:8] != MICROCODE_REV)
                  next_rteError = 1'b1;
               else
               begin
                  // Read/write bit is deliberately left unchecked
                  next_rerunCycle = frame[W_SSW][SSW_RR];
                  next_moveCountLoad = frame[W_SSW][SSW_MV];
                  next_moveContinue = frame[W_SSW][SSW_MV];
                  if (frame[W_SSW][SSW_MV])
                     next_moveCountOut = frame[W_CNT][7:0];
               end
            end
         end
         default:
            next_state = S_IDLE;
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= S_IDLE;
         idx <= 4'h0;
         last <= 4'h0;
         base <= 32'h0;
         for (int i = 0; i < WORDS_BUS_ERROR_INPUT; i++)
            frame[i] <= 16'h0;
         memReq <= 1'b0;
         memWrite <= 1'b0;
         memAddr <= 32'h0;
         memWdata <= 16'h0;
         busy <= 1'b0;
         excDone <= 1'b0;
         rteDone <= 1'b0;
         rteError <= 1'b0;
         stackPtrOut <= 32'h0;
         restoredStatus <= 16'h0;
         resumePc <= 32'h0;
         moveCountLoad <= 1'b0;
         moveCountOut <= 8'h0;
         rerunCycle <= 1'b0;
         moveContinue <= 1'b0;
      end
      else
      begin
         state <= next_state;
         idx <= next_idx;
         last <= next_last;
         base <= next_base;
         for (int i = 0; i < WORDS_BUS_ERROR_INPUT; i++)
            frame[i] <= next_frame[i];
         memReq <= next_memReq;
         memWrite <= next_memWrite;
         memAddr <= next_memAddr;
         memWdata <= next_memWdata;
         busy <= next_busy;
         excDone <= next_excDone;
         rteDone <= next_rteDone;
         rteError <= next_rteError;
         stackPtrOut <= next_stackPtrOut;
         restoredStatus <= next_restoredStatus;
         resumePc <= next_resumePc;
         moveCountLoad <= next_moveCountLoad;
         moveCountOut <= next_moveCountOut;
         rerunCycle <= next_rerunCycle;
         moveContinue <= next_moveContinue;
      end
   end
endmodule
`default_nettype wire

// ---- tb/esf_frame_builder_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module esf_frame_builder_assertions
   import esf_pkg::*;
(
   input wire logic          sys_clk,
   input wire logic          resetn,
   input wire logic          excStart,
   input wire esf_kind_type  excKind,
   input wire esf_cause_type berrCause,
   input wire logic [31:0]   stackPtr,
   input wire logic [31:0]   spBeforeFault,
   input wire logic          rteStart,
   input wire logic          memReq,
   input wire logic          memWrite,
   input wire logic [31:0]   memAddr,
   input wire logic          memAck,
   input wire logic          busy,
   input wire logic          excDone,
   input wire logic          rteDone,
   input wire logic          rteError,
   input wire logic [31:0]   stackPtrOut,
   input wire logic          moveCountLoad,
   input wire logic          moveContinue
);
   logic [3:0]   ackCnt;
   esf_kind_type kindQ;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // Count write acks of the frame in progress
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
      begin
         ackCnt <= 4'h0;
         kindQ <= K_INTERRUPT;
      end
      else if (!busy && excStart)
      begin
         ackCnt <= 4'h0;
         kindQ <= excKind;
      end
      else if (memReq && memWrite && memAck)
         ackCnt <= ackCnt + 4'h1;
   // Frame size, placement and restore handshake
   AST_SIZE: assert property (excDone |-> ackCnt == (kindQ == K_BUSERR ? WORDS_BUS_ERROR_INPUT :
      (kindQ >= K_BOUNDS ? WORDS_SIX : WORDS_FOUR))) else $error("frame size wrong");
   AST_TOP: assert property (!busy && excStart && excKind != K_BUSERR |=>
      memReq && memWrite && memAddr == $past(stackPtr) - WORD_BYTES) else $error("bad top");
   AST_EXC_TOP: assert property (!busy && excStart && excKind == K_BUSERR &&
      berrCause == C_EXC |=> memAddr == $past(spBeforeFault) - 32'h8) else $error("bad top");
   AST_DOWN: assert property ((memReq && memWrite && memAck) ##1 (memReq && memWrite) |->
      memAddr == $past(memAddr) - WORD_BYTES) else $error("not downward");
   AST_UP: assert property ((memReq && !memWrite && memAck) ##1 (memReq && !memWrite) |->
      memAddr == $past(memAddr) + WORD_BYTES) else $error("not upward");
   AST_HOLD: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
      else $error("request dropped");
   AST_SP: assert property (excDone |-> !memReq && stackPtrOut == $past(memAddr))
      else $error("bad new pointer");
   AST_RTE: assert property (!busy && rteStart && !excStart |=> memReq && !memWrite &&
      memAddr == $past(stackPtr)) else $error("bad restore start");
   AST_FLAGS: assert property (moveCountLoad || moveContinue || rteError |-> rteDone)
      else $error("flag without done");
   AST_MOVE: assert property (rteDone && !rteError |-> moveCountLoad == moveContinue)
      else $error("move flags differ");
   AST_BUSY: assert property ($rose(busy) |-> ##[1:60] !busy)
      else $error("sequence too long");
endmodule
bind esf_frame_builder esf_frame_builder_assertions chk (.sys_clk, .resetn, .excStart,
   .excKind, .berrCause, .stackPtr, .spBeforeFault, .rteStart, .memReq, .memWrite, .memAddr,
   .memAck, .busy, .excDone, .rteDone, .rteError, .stackPtrOut, .moveCountLoad, .moveContinue);
`default_nettype wire

// ---- tb/esf_stack_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module esf_stack_mem (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        slow,
   input  wire logic        memReq,
   input  wire logic        memWrite,
   input  wire logic [31:0] memAddr,
   input  wire logic [15:0] memWdata,
   output logic             memAck,
   output logic [15:0]      memRdata
);
   logic [15:0] mem [0:511];
   logic        seen;
   logic        phase;
   logic [15:0] junk;
   // Never ack in the first request cycle; every other cycle when slow
   assign memAck = memReq && seen && (!slow || phase);
   // Idle read lines show a pattern that flips every cycle
   assign memRdata = memAck ? mem[memAddr[9:1]] : junk;
   // Handshake state
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
      begin
         seen <= 1'b0;
         phase <= 1'b0;
         junk <= 16'h5A5A;
      end
      else
      begin
         seen <= memReq;
         phase <= !phase;
         junk <= ~junk;
      end
   // Stack storage, word addressed
   always @(posedge sys_clk)
      if (memAck && memWrite)
         mem[memAddr[9:1]] <= memWdata;
endmodule
`default_nettype wire

// ---- tb/esf_frame_builder_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module esf_frame_builder_test;
   import esf_pkg::*;
   localparam logic [7:0] REV = 8'h3C;  // Arbitrary revision
   logic          sys_clk, resetn, excStart, rteStart, dynSized, slow;
   esf_kind_type  excKind;
   esf_cause_type berrCause;
   logic [7:0]    excVector, moveCountIn, moveCountOut;
   logic [15:0]   statusWord, memWdata, memRdata, restoredStatus;
   logic [31:0]   nextPc, faultPc, stackPtr, spBeforeFault, faultAddr, dataBuf;
   logic [31:0]   memAddr, stackPtrOut, resumePc, base;
   logic          tracePending, bkptHigh, bkptLow, rerunIn, rmwIn, instrData, readWrite, longOp;
   logic [1:0]    remainingSize;
   logic [2:0]    functionCode;
   logic [12:0]   sswIn;
   logic          memReq, memWrite, memAck, busy, excDone, rteDone, rteError;
   logic          moveCountLoad, rerunCycle, moveContinue;
   int            fail_count = 0;
   int            checks = 0;
   assign {tracePending, bkptHigh, bkptLow, rerunIn, rmwIn, instrData, readWrite, longOp,
      remainingSize, functionCode} = sswIn;
   esf_frame_builder #(.MICROCODE_REV(REV)) dut (.*);
   esf_stack_mem stk (.*);
   // Clock
   always #12.5 sys_clk = ~sys_clk;
   // Compare and report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic cw(input int i, input logic [15:0] exp);
      chk({16'h0000, stk.mem[base[9:1] + i]}, {16'h0000, exp});
   endtask
   task automatic cpc(input int i, input logic [31:0] v);
      cw(i, v[31:16]);
      cw(i + 1, v[15:0]);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Pulse a start at this edge and wait for its done flag
   task automatic run(input logic return_from_exception);
      int n;
      excStart <= !return_from_exception;
      rteStart <= return_from_exception;
      @(posedge sys_clk);
      excStart <= 1'b0;
      rteStart <= 1'b0;
      for (n = 0; n < 200; n++)
      begin
         @(negedge sys_clk);
         if (return_from_exception ? rteDone === 1'b1 : excDone === 1'b1)
            break;
      end
      if (n == 200)
      begin
         fail_count++;
         $display("unexpected at %0t: no done flag", $time);
         print_verdict();
      end
      chk(busy, 1'b0);
   endtask
   // Four and six word frames for every kind but bus error, six word ones with a slow stack
   task automatic t_normal();
      esf_kind_type k;
      logic six;
      for (int i = 0; i < 14; i++)
      begin
         k = esf_kind_type'(i);
         six = (k >= K_BOUNDS);
         @(posedge sys_clk);
         excKind <= k;
         excVector <= 8'h40 + 8'(i);
         slow <= six;
         run(1'b0);
         base = stackPtr - (six ? 32'hC : 32'h8);
         chk(stackPtrOut, base);
         cw(W_SR, statusWord);
         cw(W_FMT, {six ? FMT_SIX : FMT_FOUR, 2'b00, excVector, 2'b00});
         cpc(W_PCH, (six || k == K_INTERRUPT || k == K_TRAPN) ? nextPc : faultPc);
         if (six)
            cpc(W_FAH, faultPc);
         // Restore the frame just stacked and check where execution resumes
         @(posedge sys_clk);
         stackPtr <= base;
         run(1'b1);
         chk(rteError, 1'b0);
         chk(resumePc, (six || k == K_INTERRUPT || k == K_TRAPN) ? nextPc : faultPc);
         chk(restoredStatus, statusWord);
         chk(stackPtrOut, base + (six ? 32'hC : 32'h8));
         @(posedge sys_clk);
         stackPtr <= 32'h00000200;
      end
      $display("normal frame test done");
   endtask
   // Bus error frames of all three types, restore and revision mismatch
   task automatic t_bus_error_input();
      logic [12:0] v;
      logic [31:0] top;
      for (int c = 0; c < 3; c++)
      begin
         v = c[0] ? 13'h1A5B : 13'h05A4;
         @(posedge sys_clk);
         excKind <= K_BUSERR;
         berrCause <= esf_cause_type'(c);
         dynSized <= c[0];
         stackPtr <= 32'h00000200;
         sswIn <= v;
         run(1'b0);
         top = (c == 2) ? spBeforeFault - 32'h6 : stackPtr;
         base = top - 32'h18;
         chk(stackPtrOut, base);
         cw(W_FMT, {FMT_BUS_ERROR_INPUT, 2'b00, excVector, 2'b00});
         cpc(W_FAH, c[0] ? faultAddr & 32'hFFFFFFFE : faultAddr);
         cpc(W_DBH, dataBuf);
         cw(W_CNT, {REV, c == 1 ? moveCountIn : 8'h00});
         cw(W_SSW, {c[1:0], 1'b0, v});
         if (c < 2)
         begin
            @(posedge sys_clk);
            stackPtr <= base;
            run(1'b1);
            chk(rteError, 1'b0);
            chk(restoredStatus, statusWord);
            chk(stackPtrOut, base + 32'h18);
            chk(moveCountLoad, c[0]);
            chk(moveContinue, c[0]);
            chk(rerunCycle, v[9]);
            chk(resumePc, nextPc);
         end
         if (c == 1)
         begin
            chk(moveCountOut, moveCountIn);
            stk.mem[base[9:1] + W_CNT][15:8] = ~REV;
            @(posedge sys_clk);
            run(1'b1);
            chk(rteError, 1'b1);
            chk(moveCountLoad, 1'b0);
            // Unknown format code stops the restore with an error
            stk.mem[base[9:1] + W_FMT][15:12] = 4'h5;
            @(posedge sys_clk);
            run(1'b1);
            chk(rteError, 1'b1);
            chk(moveContinue, 1'b0);
         end
      end
      $display("bus error frame test done");
   endtask
   // Reset, then the scenarios
   initial
   begin
      sys_clk = 1'b0;
      resetn = 1'b0;
      {excStart, rteStart, dynSized, slow} = 4'h0;
      excKind = K_INTERRUPT;
      berrCause = C_NORMAL;
      excVector = 8'h00;
      moveCountIn = 8'h05;
      statusWord = 16'h2704;
      nextPc = 32'h00001000;
      faultPc = 32'h00000FFA;
      stackPtr = 32'h00000200;
      spBeforeFault = 32'h00000300;
      faultAddr = 32'h00012345;
      dataBuf = 32'hCAFE1234;
      sswIn = 13'h0000;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      t_normal();
      t_bus_error_input();
      print_verdict();
   end
endmodule
`default_nettype wire
